// >>> verilog/bphp_pkg.sv
// bphp_pkg: constants and state codes for the bidirectional parallel host port
// assumes an 8-bit host data bus and four status lines carrying return nibbles
package bphp_pkg;
    localparam int unsigned DATA_W  = 8;   // host data lines
    localparam int unsigned NIB_W   = 4;   // status lines used for return data
    localparam int unsigned SYNC_W  = 2;   // flip-flops per pin synchroniser
    // position of each return bit on the status lines
    localparam int unsigned NIB_ACK = 0;
    localparam int unsigned NIB_PE  = 1;
    localparam int unsigned NIB_SEL = 2;
    localparam int unsigned NIB_ERR = 3;
    // reset levels of the host-facing outputs
    localparam logic        BUSY_RST = 1'h0;
    localparam logic [3:0]  NIB_RST  = 4'h0;

    typedef enum logic [2:0] {
        BPHP_IDLE    = 3'h0,  // free, busy low
        BPHP_RX_HOLD = 3'h1,  // byte taken, busy high until consumed and echoed high (strobe released when chained)
        BPHP_RX_REL  = 3'h2,  // busy low, waiting for host to echo low
        BPHP_TX_SET  = 3'h3,  // nibble on status lines, busy still low
        BPHP_TX_BUSY = 3'h4,  // busy high, waiting for host to echo high
        BPHP_TX_REL  = 3'h5   // busy low, waiting for host to echo low
    } bphp_state_t;
endpackage

// >>> verilog/bphp_buf2.sv
// bphp_buf2: two-entry buffer with valid/ready on both sides
// assumes one clock; output data and valid come straight from registers
`timescale 1ns/10ps
module bphp_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic             head_v_q;
    logic [WIDTH-1:0] head_q;
    logic             skid_v_q;
    logic [WIDTH-1:0] skid_q;
    wire              push = in_valid && !skid_v_q;
    wire              pop  = head_v_q && out_ready;

    // ready only depends on the spare slot, so a stalled reader fills both entries
    assign in_ready  = !skid_v_q;
    assign out_valid = head_v_q;
    assign out_data  = head_q;

    // head feeds the reader, skid catches a word that arrives during a stall
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            head_v_q <= 1'b0;
            skid_v_q <= 1'b0;
            head_q   <= '0;
            skid_q   <= '0;
        end else begin
            if (!head_v_q || pop) begin
                head_v_q <= skid_v_q || push;
                head_q   <= skid_v_q ? skid_q : in_data;
                skid_v_q <= skid_v_q && push;
                if (skid_v_q && push) begin
                    skid_q <= in_data;
                end
            end else if (push) begin
                skid_v_q <= 1'b1;
                skid_q   <= in_data;
            end
        end
    end
endmodule

// >>> verilog/bphp_port.sv
// bphp_port: device end of a bidirectional printer-style parallel host port
// assumes host pins are asynchronous to ref_clk; strobe and autofeed are active low
// Overview of operation
// - a host strobe pulse makes the device capture the eight data lines
// - busy stays high until the byte is consumed and the host echoes high, or while return data waits
// - return nibble goes on ack, pe, select, error, then busy is raised
// - a chained second unit strobes on autofeed and reports busy on pe
// - chained second unit only downloads; no return data over this port
`timescale 1ns/10ps
module bphp_port #(
    parameter int unsigned DATA_W = bphp_pkg::DATA_W
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic [DATA_W-1:0] host_data,
    input  wire logic              strobe_n,
    input  wire logic              autofeed_n,
    input  wire logic              selectin,
    input  wire logic              chain_second,
    output logic                   busy,
    output logic                   ack,
    output logic                   pe,
    output logic                   select_out,
    output logic                   error,
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output logic [DATA_W-1:0]      rx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    input  wire logic [DATA_W-1:0] tx_data
);
    localparam int unsigned NW = bphp_pkg::NIB_W;

    // pin synchronisers: stage one is read only by stage two
    logic [DATA_W-1:0] data_s1_q, data_s2_q;
    logic              stb_s1_q, stb_s2_q, stb_s3_q;
    logic              afd_s1_q, afd_s2_q, afd_s3_q;
    logic              sel_s1_q, sel_s2_q;
    logic              chn_s1_q, chn_s2_q;

    always_ff @(posedge ref_clk) begin
        data_s1_q <= host_data;
        data_s2_q <= data_s1_q;
        stb_s1_q  <= strobe_n;
        stb_s2_q  <= stb_s1_q;
        stb_s3_q  <= stb_s2_q;
        afd_s1_q  <= autofeed_n;
        afd_s2_q  <= afd_s1_q;
        afd_s3_q  <= afd_s2_q;
        sel_s1_q  <= selectin;
        sel_s2_q  <= sel_s1_q;
        chn_s1_q  <= chain_second;
        chn_s2_q  <= chn_s1_q;
    end

    // chained role picks the strobe source; edges are taken from the settled stages
    wire chained   = chn_s2_q;
    wire stb_fall  = stb_s3_q && !stb_s2_q;
    wire afd_fall  = afd_s3_q && !afd_s2_q;
    wire byte_edge = chained ? afd_fall : stb_fall;
    wire stb_level = chained ? !afd_s2_q : !stb_s2_q;
    wire host_echo = sel_s2_q;

    bphp_pkg::bphp_state_t state_q, state_d;
    logic [DATA_W-1:0]     rx_byte_q;
    logic                  rx_pend_q;
    logic                  pushed_q;
    logic [DATA_W-1:0]     tx_byte_q;
    logic                  hi_half_q;
    logic                  busy_q, busy_d;
    logic [NW-1:0]         nib_q, nib_d;
    logic                  tx_ready_q;

    // buffer between the capture register and the user side
    wire buf_in_valid = (state_q == bphp_pkg::BPHP_RX_HOLD) && !pushed_q;
    wire buf_in_ready;
    wire push_ok      = buf_in_valid && buf_in_ready;
    wire consumed     = pushed_q || push_ok;
    // refuse a strobe while the held byte has not reached the buffer yet,
    // so a host that ignores busy can neither overwrite it nor queue a duplicate
    wire rx_full      = (state_q == bphp_pkg::BPHP_RX_HOLD) && !consumed;
    wire rx_take      = byte_edge && !rx_pend_q && !rx_full;
    wire tx_take      = tx_valid && tx_ready_q;
    // the standalone unit waits for the echo; a chained unit cannot, since
    // selectin belongs to the first unit, so it waits for strobe release instead
    wire rx_echo_hi   = chained ? !stb_level : host_echo;
    wire rx_echo_lo   = chained ? 1'b1 : !host_echo;

    bphp_buf2 #(
        .WIDTH(DATA_W)
    ) u_buf (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .in_valid (buf_in_valid),
        .in_ready (buf_in_ready),
        .in_data  (rx_byte_q),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data (rx_data)
    );

    // next state and pin levels of the handshake
    always_comb begin
        state_d = state_q;
        busy_d  = busy_q;
        nib_d   = nib_q;
        case (state_q)
            bphp_pkg::BPHP_IDLE: begin
                busy_d = 1'b0;
                if (rx_pend_q) begin
                    state_d = bphp_pkg::BPHP_RX_HOLD;
                    busy_d  = 1'b1;
                end else if (tx_take) begin
                    state_d = bphp_pkg::BPHP_TX_SET;
                    nib_d   = tx_data[NW-1:0];
                end
            end
            bphp_pkg::BPHP_RX_HOLD: begin
                busy_d = 1'b1;
                if (consumed && rx_echo_hi) begin
                    state_d = bphp_pkg::BPHP_RX_REL;
                    busy_d  = 1'b0;
                end
            end
            bphp_pkg::BPHP_RX_REL: begin
                if (rx_echo_lo) begin
                    state_d = bphp_pkg::BPHP_IDLE;
                end
            end
            bphp_pkg::BPHP_TX_SET: begin
                // nibble already stands one cycle before busy rises
                state_d = bphp_pkg::BPHP_TX_BUSY;
                busy_d  = 1'b1;
            end
            bphp_pkg::BPHP_TX_BUSY: begin
                if (host_echo) begin
                    state_d = bphp_pkg::BPHP_TX_REL;
                    busy_d  = 1'b0;
                end
            end
            bphp_pkg::BPHP_TX_REL: begin
                if (!host_echo) begin
                    if (!hi_half_q) begin
                        state_d = bphp_pkg::BPHP_TX_SET;
                        nib_d   = tx_byte_q[DATA_W-1 -: NW];
                    end else begin
                        state_d = bphp_pkg::BPHP_IDLE;
                    end
                end
            end
            default: begin
                state_d = bphp_pkg::BPHP_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // handshake registers; a strobe is dropped while one is pending or held and not yet in the buffer, pending flag set wins over clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q   <= bphp_pkg::BPHP_IDLE;
            rx_byte_q <= '0;
            rx_pend_q <= 1'b0;
            pushed_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (rx_take) begin
                rx_byte_q <= data_s2_q;
            end
            rx_pend_q <= rx_take || (rx_pend_q && state_q != bphp_pkg::BPHP_IDLE);
            if (state_q == bphp_pkg::BPHP_RX_HOLD) begin
                pushed_q <= consumed;
            end else begin
                pushed_q <= 1'b0;
            end
        end
    end

    // return path registers; a chained unit never offers to take return data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_byte_q  <= '0;
            hi_half_q  <= 1'b0;
            tx_ready_q <= 1'b0;
        end else begin
            tx_ready_q <= (state_d == bphp_pkg::BPHP_IDLE) && !chained
                          && !byte_edge && !rx_pend_q && !tx_take;
            if (state_q == bphp_pkg::BPHP_IDLE && tx_take && !rx_pend_q) begin
                tx_byte_q <= tx_data;
                hi_half_q <= 1'b0;
            end else if (state_q == bphp_pkg::BPHP_TX_REL && !host_echo) begin
                hi_half_q <= 1'b1;
            end
        end
    end

    // output pins; in chained role busy moves to pe and busy stays low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_q     <= bphp_pkg::BUSY_RST;
            nib_q      <= bphp_pkg::NIB_RST;
            busy       <= bphp_pkg::BUSY_RST;
            ack        <= 1'b0;
            pe         <= 1'b0;
            select_out <= 1'b0;
            error      <= 1'b0;
        end else begin
            busy_q     <= busy_d;
            nib_q      <= nib_d;
            busy       <= chained ? 1'b0 : busy_d;
            ack        <= nib_d[bphp_pkg::NIB_ACK];
            pe         <= chained ? busy_d : nib_d[bphp_pkg::NIB_PE];
            select_out <= nib_d[bphp_pkg::NIB_SEL];
            error      <= nib_d[bphp_pkg::NIB_ERR];
        end
    end

    // the offer to the user side is the registered level itself
    assign tx_ready = tx_ready_q;
endmodule

// >>> testbench/bphp_port_monitor.sv
// bphp_port_monitor: pin and stream protocol checks for bphp_port
// assumes one clock with a sync reset; bound into the port below
`timescale 1ns/10ps
module bphp_port_monitor (
    input wire logic       ref_clk, reset, strobe_n, autofeed_n, selectin, chain_second,
    input wire logic       busy, ack, pe, select_out, error,
    input wire logic       rx_valid, rx_ready, tx_valid, tx_ready,
    input wire logic [7:0] rx_data, tx_data
);
    logic [3:0] lo_q;
    wire  [3:0] nib = {error, select_out, pe, ack};
    // keep the low nibble, since tx_data may move on after the hand-off
    always_ff @(posedge ref_clk) if (tx_valid && tx_ready) lo_q <= tx_data[3:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_strobe_busy: assert property ($fell(strobe_n) && !busy
        && !selectin && !chain_second |-> ##[2:10] busy) else $error("busy missed a strobe");
    a_fall_echo: assert property ($fell(busy) |-> $past(selectin))
        else $error("busy fell before the echo");
    a_rise_echo: assert property ($rose(busy) |-> !$past(selectin))
        else $error("busy rose while echo high");
    a_nib_held: assert property (busy |=> !busy || $stable(nib))
        else $error("nibble moved under busy");
    a_nib_first: assert property ($rose(busy) |-> $stable(nib))
        else $error("nibble not set before busy");
    a_tx_low: assert property (tx_valid && tx_ready |-> ##[1:4] (busy && nib == lo_q))
        else $error("low nibble not sent first");
    a_tx_once: assert property (tx_valid && tx_ready |=> !tx_ready)
        else $error("tx_ready stayed up");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx word lost in stall");
    a_chain_quiet: assert property (chain_second && $past(chain_second, 4)
        |-> !busy && !tx_ready) else $error("chained unit used busy or tx");
    a_chain_pe: assert property ($fell(autofeed_n) && chain_second
        && $past(chain_second, 4) |-> ##[2:10] pe) else $error("pe missed autofeed");
    c_rx: cover property ($rose(busy) && !tx_ready);
    c_stall: cover property (rx_valid && !rx_ready);
    c_tx: cover property (tx_valid && tx_ready);
endmodule
bind bphp_port bphp_port_monitor bphp_port_monitor_inst (.*);

// >>> testbench/bphp_host_model.sv
// bphp_host_model: host side of the port, strobes bytes and echoes busy
// assumes the bphp_port pins; acts only at falling edges of ref_clk
`timescale 1ns/10ps
module bphp_host_model (
    input wire logic       ref_clk, reset, chain, busy,
    input wire logic [2:0] lag,
    input wire logic [3:0] nib,
    output logic [7:0]     host_data = 8'h00,
    output logic           strobe_n = 1'h1, autofeed_n = 1'h1, selectin = 1'h0,
    output logic           got_v = 1'h0,
    output logic [7:0]     got_byte = 8'h00
);
    logic [7:0] hist = 8'h00;
    logic [3:0] lo = 4'h0;
    logic       half = 1'h0, pend = 1'h0, bprev = 1'h0;
    wire        bz = chain ? nib[1] : busy;
    // strobe held long enough that busy is up before release
    task automatic send(input logic [7:0] b);
        int i;
        pend = 1'h1;
        host_data = b;
        repeat (3) @(negedge ref_clk);
        if (chain) autofeed_n = 1'h0; else strobe_n = 1'h0;
        repeat (8) @(negedge ref_clk);
        strobe_n = 1'h1;
        autofeed_n = 1'h1;
        for (i = 0; i < 400 && bz; i++) @(negedge ref_clk);
        host_data = ~b; // hold over: lines stop showing the byte
        repeat (lag + 4) @(negedge ref_clk);
        pend = 1'h0;
    endtask
    // echo busy after lag + 1 cycles; the chained unit gets no echo
    always @(negedge ref_clk) begin
        hist <= {hist[6:0], busy};
        selectin <= !reset && !chain && hist[lag];
        got_v <= 1'h0;
        bprev <= busy;
        if (reset) half <= 1'h0;
        else if (busy && !bprev && !pend && !chain) begin
            lo <= nib;
            half <= !half;
            got_v <= half;
            got_byte <= {nib, lo};
        end
    end
endmodule

// >>> testbench/tb_bphp_port.sv
// tb_bphp_port: self-checking bench for the parallel host port
// assumes bphp_pkg, bphp_port, the host model and the monitor are compiled
`timescale 1ns/10ps
module tb_bphp_port;
    logic       ref_clk = 1'h0, reset = 1'h1, chain_second = 1'h0, rx_ready = 1'h1;
    logic       tx_valid = 1'h0, hold = 1'h0, stall = 1'h0;
    logic [7:0] tx_data = 8'h00;
    logic [2:0] lag = 3'h1;
    wire  [7:0] host_data, rx_data, got_byte;
    wire        strobe_n, autofeed_n, selectin, busy, ack, pe, select_out, error;
    wire        rx_valid, tx_ready, got_v;
    logic [7:0] rxq[$], txq[$];
    int         seed = 88405, err_total = 0, checked = 0, cyc = 0;
    initial forever #10 ref_clk = !ref_clk;
    bphp_port bphp_port_inst (.ref_clk(ref_clk), .reset(reset), .host_data(host_data),
        .strobe_n(strobe_n), .autofeed_n(autofeed_n), .selectin(selectin),
        .chain_second(chain_second), .busy(busy), .ack(ack), .pe(pe), .select_out(select_out),
        .error(error), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
    bphp_host_model bphp_host_model_inst (.ref_clk(ref_clk), .reset(reset),
        .chain(chain_second), .busy(busy), .lag(lag), .nib({error, select_out, pe, ack}),
        .host_data(host_data), .strobe_n(strobe_n), .autofeed_n(autofeed_n),
        .selectin(selectin), .got_v(got_v), .got_byte(got_byte));
    task automatic check(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the note goes in the queue before the byte leaves the host
    task automatic host_byte(input logic [7:0] b);
        rxq.push_back(b);
        lag = 3'($random(seed));
        bphp_host_model_inst.send(b);
    endtask
    task automatic tx_byte(input logic [7:0] b);
        int i;
        @(negedge ref_clk);
        txq.push_back(b);
        tx_data = b;
        tx_valid = 1'h1;
        for (i = 0; i < 500; i++) begin
            @(posedge ref_clk);
            if (tx_ready === 1'h1) break;
        end
        @(negedge ref_clk);
        tx_valid = 1'h0;
    endtask
    // receiver side stalls at random while stall is set
    always @(negedge ref_clk) rx_ready <= !hold && (!stall || $random(seed) % 2 == 0);
    // watcher: each delivered byte is matched to the oldest note
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            $display("ERROR %0t: run did not finish in time", $time);
            finish_test();
        end
        if (rx_valid === 1'h1 && rx_ready === 1'h1) begin
            check(rxq.size() ? rxq.pop_front() : 8'hxx, rx_data);
        end
        if (got_v === 1'h1) check(txq.size() ? txq.pop_front() : 8'hxx, got_byte);
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        repeat (3) @(negedge ref_clk);
        host_byte(8'h00);
        host_byte(8'hff);
        stall = 1'h1;
        repeat (6) host_byte(8'($random(seed)));
        stall = 1'h0;
        // drain the buffer first, so exactly two words fill it while the reader holds off
        repeat (4) @(negedge ref_clk);
        hold = 1'h1;
        host_byte(8'h5a);
        host_byte(8'ha5);
        fork
            host_byte(8'h3c);
            begin
                repeat (40) @(negedge ref_clk);
                check(8'h01, {7'h00, busy});
                hold = 1'h0;
            end
        join
        tx_byte(8'ha5);
        tx_byte(8'h3c);
        tx_byte(8'($random(seed)));
        for (int i = 0; i < 500 && tx_ready !== 1'h1; i++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chain_second = 1'h1;
        repeat (5) @(negedge ref_clk);
        host_byte(8'hc3);
        host_byte(8'($random(seed)));
        tx_valid = 1'h1;
        repeat (8) begin
            @(negedge ref_clk);
            check(8'h00, {7'h00, tx_ready});
        end
        tx_valid = 1'h0;
        repeat (10) @(negedge ref_clk);
        check(8'h00, 8'(rxq.size() + txq.size()));
        finish_test();
    end
endmodule
